// >>> mode_s_sd_decoder.sv
// Purpose: Decode uplink designator subfields and fill reply status fields
// Assumes: One uplink word per uplink_valid_in pulse, parity already checked
// Notes:   Registers over AXI4-Lite; timed commands run from clk_in
`timescale 1ns/100ps
`include "mode_s_consts.svh"
module mode_s_sd_decoder
  import mode_s_pkg::*;
#(
  parameter logic [35:0] ANT_HOLD_CYC  = 36'(`ANT_HOLD_S) * 36'(`CLK_HZ),
  parameter logic [35:0] POS_SHORT_CYC = 36'(`POS_SHORT_S) * 36'(`CLK_HZ),
  parameter logic [35:0] POS_LONG_CYC  = 36'(`POS_LONG_S) * 36'(`CLK_HZ)
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        uplink_valid_in,
  input  wire logic [31:0] uplink_in,
  input  wire logic        squitter_in,
  input  wire logic        reply_req_in,
  input  wire logic [4:0]  reply_df_in,
  input  wire logic [31:0] reply_base_in,
  output logic             reply_valid_out,
  output logic [31:0]      reply_out,
  output logic [3:0]       bds2_out,
  output logic [5:0]       si_code_out,
  output logic             antenna_bottom_out,
  output logic             surface_pos_out,
  output logic             unlinked_msg_out,
  output logic             link_done_out,
  output logic [2:0]       link_count_out
);
  uplink_fields_t fld;
  util_msg_t      um;
  ant_mode_t      ant_mode;
  link_state_t    link_state;
  logic [2:0]     sens_level;
  logic [3:0]     last_tms;
  logic           link_err;
  logic           link_err_set;
  logic           ant_load;
  logic           ant_cancel;
  logic           ant_busy;
  logic           ant_expire;
  logic           pos_load;
  logic           pos_cancel;
  logic [35:0]    pos_count;
  logic           pos_busy;
  logic           ant_toggle;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [31:0]    wr_data;
  logic [3:0]     wr_strb;
  logic           wr_ok;
  logic [31:0]    rd_data;
  logic           rd_ok;
  logic           sd_rsv;
  logic           sd_surf;
  logic           sd_si;
  logic           sd_rr;
  logic           sd_tms;
  logic [31:0]    next_reply;
  // Format is decoded first; subfields mean nothing outside these formats
  always_comb begin
    fld.uf    = uplink_in[`UF_HI:`UF_LO];
    fld.di    = uplink_in[`DI_HI:`DI_LO];
    fld.iis   = uplink_in[`IIS_HI:`IIS_LO];
    fld.sis   = uplink_in[`SIS_HI:`SIS_LO];
    fld.rrs   = uplink_in[`RRS_HI:`RRS_LO];
    fld.tcs   = uplink_in[`TCS_HI:`TCS_LO];
    fld.rss   = uplink_in[`RSS_HI:`RSS_LO];
    fld.tms   = uplink_in[`TMS_HI:`TMS_LO];
    fld.sd_ok = uplink_valid_in &&
                (fld.uf == `FMT_SURV_ALT || fld.uf == `FMT_SURV_ID ||
                 fld.uf == `FMT_COMMA_ALT || fld.uf == `FMT_COMMA_ID);
  end
  // Designator identification selects the layout of bits 17-32
  assign sd_rsv  = fld.sd_ok && fld.di == `DI_RSV;
  assign sd_surf = fld.sd_ok && fld.di == `DI_SURF;
  assign sd_si   = fld.sd_ok && fld.di == `DI_SI;
  assign sd_rr   = fld.sd_ok && fld.di == `DI_RR;
  assign sd_tms  = sd_rsv || sd_rr;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bds2_out <= 4'h0;
    end else if (sd_rr) begin
      bds2_out <= fld.rrs;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      si_code_out <= 6'h00;
    end else if (sd_si) begin
      si_code_out <= fld.sis;
    end
  end
  // Reservation code zero is no request and leaves the readout alone
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      um <= '0;
    end else if (sd_rsv && fld.rss != `RSS_NONE) begin
      um.rsv_type <= fld.rss;
      um.holder   <= fld.iis;
    end
  end
  // Antenna command decode feeding the 120 s hold
  always_comb begin
    ant_load   = 1'b0;
    ant_cancel = 1'b0;
    if (sd_surf) begin
      unique case (fld.rss)
        `SAS_TOP:     ant_cancel = 1'b1;
        `SAS_ALT:     ant_load   = 1'b1;
        `SAS_BOTTOM:  ant_load   = 1'b1;
        `SAS_DEFAULT: ant_cancel = 1'b1;
      endcase
    end
  end

  hold_timer #(
    .W (36)
  ) ant_timer (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (ant_load),
    .count_in   (ANT_HOLD_CYC),
    .cancel_in  (ant_cancel),
    .busy_out   (ant_busy),
    .expire_out (ant_expire)
  );
  // A fresh command in the expiry cycle wins over the revert
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ant_mode <= ANT_TOP;
    end else if (sd_surf) begin
      unique case (fld.rss)
        `SAS_ALT:    ant_mode <= ANT_ALT;
        `SAS_BOTTOM: ant_mode <= ANT_BOTTOM;
        default:     ant_mode <= ANT_TOP;
      endcase
    end else if (ant_expire) begin
      ant_mode <= ANT_TOP;
    end
  end

  // Alternation steps once per squitter so consecutive squitters differ
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ant_toggle         <= 1'b0;
      antenna_bottom_out <= 1'b0;
    end else begin
      if (squitter_in) begin
        ant_toggle <= ~ant_toggle;
      end
      unique case (ant_mode)
        ANT_TOP:    antenna_bottom_out <= 1'b0;
        ANT_ALT:    antenna_bottom_out <= ant_toggle;
        ANT_BOTTOM: antenna_bottom_out <= 1'b1;
        default:    antenna_bottom_out <= 1'b0;
      endcase
    end
  end

  // Type control codes 4-7 fall through untouched
  always_comb begin
    pos_load   = 1'b0;
    pos_cancel = 1'b0;
    pos_count  = POS_SHORT_CYC;
    if (sd_surf) begin
      if (fld.tcs == `TCS_SHORT) begin
        pos_load = 1'b1;
      end else if (fld.tcs == `TCS_LONG) begin
        pos_load  = 1'b1;
        pos_count = POS_LONG_CYC;
      end else if (fld.tcs == `TCS_CANCEL) begin
        pos_cancel = 1'b1;
      end
    end
  end

  hold_timer #(
    .W (36)
  ) pos_timer (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .load_in    (pos_load),
    .count_in   (pos_count),
    .cancel_in  (pos_cancel),
    .busy_out   (pos_busy),
    .expire_out ()
  );
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      surface_pos_out <= 1'b0;
    end else begin
      surface_pos_out <= pos_busy;
    end
  end

  // Linked segments must arrive first, second, third in order; final is accepted after any of them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_state       <= LNK_IDLE;
      link_count_out   <= 3'h0;
      link_done_out    <= 1'b0;
      unlinked_msg_out <= 1'b0;
      link_err_set     <= 1'b0;
      last_tms         <= 4'h0;
    end else begin
      link_done_out    <= 1'b0;
      unlinked_msg_out <= 1'b0;
      link_err_set     <= 1'b0;
      if (sd_tms) begin
        last_tms <= fld.tms;
        if (fld.tms == `TMS_NONE) begin
          link_state <= link_state;
        end else if (fld.tms <= `TMS_UNL_HI) begin
          unlinked_msg_out <= 1'b1;
        end else if (fld.tms <= `TMS_LINK_HI) begin
          link_err_set   <= (link_state != LNK_IDLE);
          link_state     <= LNK_SEG1;
          link_count_out <= 3'h1;
        end else if (fld.tms == `TMS_SEG2) begin
          if (link_state == LNK_SEG1) begin
            link_state     <= LNK_SEG2;
            link_count_out <= 3'h2;
          end else begin
            link_err_set <= 1'b1;
          end
        end else if (fld.tms == `TMS_SEG3) begin
          if (link_state == LNK_SEG2) begin
            link_state     <= LNK_SEG3;
            link_count_out <= 3'h3;
          end else begin
            link_err_set <= 1'b1;
          end
        end else if (fld.tms == `TMS_FINAL) begin
          if (link_state != LNK_IDLE) begin
            link_state     <= LNK_IDLE;
            link_count_out <= link_count_out + 3'h1;
            link_done_out  <= 1'b1;
          end else begin
            link_err_set <= 1'b1;
          end
        end
      end
    end
  end
  // Reply field placement; level zero is sent as is, receiver qualifies it
  always_comb begin
    next_reply                = reply_base_in;
    next_reply[`DF_HI:`DF_LO] = reply_df_in;
    if (reply_df_in == `FMT_AIR_SHORT || reply_df_in == `FMT_AIR_LONG) begin
      next_reply[`SL_HI:`SL_LO] = sens_level;
    end else if (reply_df_in == `FMT_SURV_ALT || reply_df_in == `FMT_SURV_ID ||
                 reply_df_in == `FMT_COMMA_ALT || reply_df_in == `FMT_COMMA_ID) begin
      next_reply[`UM_HI:`UM_LO] = um;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reply_out       <= 32'h0;
      reply_valid_out <= 1'b0;
    end else begin
      reply_valid_out <= reply_req_in;
      if (reply_req_in) begin
        reply_out <= next_reply;
      end
    end
  end

  axil_slave #(
    .AW (8)
  ) bus (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .awvalid_in  (s_axi_awvalid_in),
    .awready_out (s_axi_awready_out),
    .awaddr_in   (s_axi_awaddr_in),
    .wvalid_in   (s_axi_wvalid_in),
    .wready_out  (s_axi_wready_out),
    .wdata_in    (s_axi_wdata_in),
    .wstrb_in    (s_axi_wstrb_in),
    .bvalid_out  (s_axi_bvalid_out),
    .bready_in   (s_axi_bready_in),
    .bresp_out   (s_axi_bresp_out),
    .arvalid_in  (s_axi_arvalid_in),
    .arready_out (s_axi_arready_out),
    .araddr_in   (s_axi_araddr_in),
    .rvalid_out  (s_axi_rvalid_out),
    .rready_in   (s_axi_rready_in),
    .rdata_out   (s_axi_rdata_out),
    .rresp_out   (s_axi_rresp_out),
    .wr_en_out   (wr_en),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_ok_in    (wr_ok),
    .rd_data_in  (rd_data),
    .rd_ok_in    (rd_ok)
  );
  assign wr_ok = (wr_addr == `REG_CTRL) || (wr_addr == `REG_LINK);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sens_level <= `CTRL_RST;
    end else if (wr_en && wr_addr == `REG_CTRL && wr_strb[0]) begin
      sens_level <= wr_data[2:0];
    end
  end
  // Segment error is sticky; a new error beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_err <= 1'b0;
    end else if (link_err_set) begin
      link_err <= 1'b1;
    end else if (wr_en && wr_addr == `REG_LINK && wr_strb[0] &&
                 wr_data[`LINK_ERR_BIT]) begin
      link_err <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr_in)
      `REG_CTRL:   rd_data[2:0] = sens_level;
      `REG_STATUS: rd_data = {4'h0, ant_busy, pos_busy, ant_mode, um,
                              si_code_out, bds2_out, fld.di, fld.uf};
      `REG_LINK:   rd_data[7:0] = {link_err, link_count_out, last_tms};
      default:     rd_ok = 1'b0;
    endcase
  end
endmodule

// >>> mode_s_consts.svh
// Purpose: Shared constants for the designator field decoder
// Assumes: Message bit n (1 = first sent) sits at word bit 32-n
// Notes:   Field limits are word bit indices, high then low
`ifndef MODE_S_CONSTS_SVH
`define MODE_S_CONSTS_SVH

`define CLK_HZ        40000000
`define ANT_HOLD_S    120
`define POS_SHORT_S   15
`define POS_LONG_S    60

`define UF_HI         31
`define UF_LO         27
`define DI_HI         18
`define DI_LO         16
`define SD_HI         15
`define SD_LO         0
`define IIS_HI        15
`define IIS_LO        12
`define SIS_HI        15
`define SIS_LO        10
`define RRS_HI        11
`define RRS_LO        8
`define TCS_HI        11
`define TCS_LO        9
`define RSS_HI        5
`define RSS_LO        4
`define TMS_HI        3
`define TMS_LO        0
`define DF_HI         31
`define DF_LO         27
`define SL_HI         23
`define SL_LO         21
`define UM_HI         18
`define UM_LO         13

`define DI_RSV        3'h1
`define DI_SURF       3'h2
`define DI_SI         3'h3
`define DI_RR         3'h7
`define FMT_SURV_ALT  5'h04
`define FMT_SURV_ID   5'h05
`define FMT_COMMA_ALT 5'h14
`define FMT_COMMA_ID  5'h15
`define FMT_AIR_SHORT 5'h00
`define FMT_AIR_LONG  5'h10

`define SAS_TOP       2'h0
`define SAS_ALT       2'h1
`define SAS_BOTTOM    2'h2
`define SAS_DEFAULT   2'h3
`define TCS_SHORT     3'h1
`define TCS_LONG      3'h2
`define TCS_CANCEL    3'h3
`define RSS_NONE      2'h0
`define TMS_NONE      4'h0
`define TMS_UNL_HI    4'h3
`define TMS_LINK_HI   4'hB
`define TMS_SEG2      4'hC
`define TMS_SEG3      4'hD
`define TMS_FINAL     4'hE

`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_LINK      8'h08
`define LINK_ERR_BIT  7
`define CTRL_RST      3'h0
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// >>> mode_s_pkg.sv
// Purpose: Types for the designator field decoder
// Assumes: Constants come from mode_s_consts.svh
// Notes:   Util message layout is holder first, then type, as sent
package mode_s_pkg;
  typedef enum logic [1:0] {ANT_TOP, ANT_ALT, ANT_BOTTOM} ant_mode_t;
  typedef enum logic [1:0] {LNK_IDLE, LNK_SEG1, LNK_SEG2, LNK_SEG3} link_state_t;
  typedef struct packed {
    logic [4:0] uf;
    logic [2:0] di;
    logic [3:0] iis;
    logic [5:0] sis;
    logic [3:0] rrs;
    logic [2:0] tcs;
    logic [1:0] rss;
    logic [3:0] tms;
    logic       sd_ok;
  } uplink_fields_t;
  typedef struct packed {
    logic [3:0] holder;
    logic [1:0] rsv_type;
  } util_msg_t;
endpackage

// >>> hold_timer.sv
// Purpose: Down counter that marks the end of a timed command
// Assumes: count_in is at least one
// Notes:   A load in the expiry cycle restarts the hold
`timescale 1ns/100ps
module hold_timer #(
  parameter int W = 36
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  input  wire logic         cancel_in,
  output logic              busy_out,
  output logic              expire_out
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt        <= '0;
      busy_out   <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (load_in) begin
        cnt      <= count_in;
        busy_out <= 1'b1;
      end else if (cancel_in) begin
        busy_out <= 1'b0;
      end else if (busy_out) begin
        cnt <= cnt - 1'b1;
        if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_out   <= 1'b0;
          expire_out <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> axil_slave.sv
// Purpose: AXI4-Lite slave front end with one write and one read in flight
// Assumes: The register file decodes wr_addr_out and s_axi_araddr_in itself
// Notes:   Address and data are taken in either order; response after both
`timescale 1ns/100ps
`include "mode_s_consts.svh"
module axil_slave #(
  parameter int AW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          awvalid_in,
  output logic               awready_out,
  input  wire logic [AW-1:0] awaddr_in,
  input  wire logic          wvalid_in,
  output logic               wready_out,
  input  wire logic [31:0]   wdata_in,
  input  wire logic [3:0]    wstrb_in,
  output logic               bvalid_out,
  input  wire logic          bready_in,
  output logic [1:0]         bresp_out,
  input  wire logic          arvalid_in,
  output logic               arready_out,
  input  wire logic [AW-1:0] araddr_in,
  output logic               rvalid_out,
  input  wire logic          rready_in,
  output logic [31:0]        rdata_out,
  output logic [1:0]         rresp_out,
  output logic               wr_en_out,
  output logic [AW-1:0]      wr_addr_out,
  output logic [31:0]        wr_data_out,
  output logic [3:0]         wr_strb_out,
  input  wire logic          wr_ok_in,
  input  wire logic [31:0]   rd_data_in,
  input  wire logic          rd_ok_in
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      bvalid_out  <= 1'b0;
      bresp_out   <= `RESP_OKAY;
      wr_en_out   <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= 32'h0;
      wr_strb_out <= 4'h0;
    end else begin
      wr_en_out <= 1'b0;
      if (awvalid_in && awready_out) begin
        awready_out <= 1'b0;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        wready_out  <= 1'b0;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      // Both halves held and no response pending
      if (!awready_out && !wready_out && !bvalid_out && !wr_en_out) begin
        wr_en_out  <= 1'b1;
        bvalid_out <= 1'b1;
        bresp_out  <= wr_ok_in ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_out <= 1'b1;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0;
      rresp_out   <= `RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b1;
      rdata_out   <= rd_data_in;
      rresp_out   <= rd_ok_in ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_out && rready_in) begin
      rvalid_out  <= 1'b0;
      arready_out <= 1'b1;
    end
  end
endmodule

// >>> mode_s_sd_decoder_sva.sv
// Purpose: Port checks for the designator decoder
// Assumes: Message bit n sits at uplink_in[32-n]
// Notes:   Bound to every decoder
`timescale 1ns/100ps
module mode_s_sd_decoder_sva #(
  parameter logic [35:0] ANT_HOLD_CYC = 36'h14
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        uplink_valid_in,
  input wire logic [31:0] uplink_in,
  input wire logic [3:0]  bds2_out,
  input wire logic [5:0]  si_code_out,
  input wire logic        antenna_bottom_out,
  input wire logic        surface_pos_out,
  input wire logic        unlinked_msg_out,
  input wire logic        link_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic        sd;
  logic        unl;
  logic [2:0]  di;
  logic [35:0] held;
  assign sd  = uplink_valid_in && (uplink_in[31:27] inside {5'h04, 5'h05, 5'h14, 5'h15});
  assign di  = uplink_in[18:16];
  assign unl = sd && (di inside {3'h1, 3'h7}) && (uplink_in[3:0] inside {[4'h1:4'h3]});
  // Any antenna command restarts the count, so a renewed hold is legal
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) held <= 36'h0;
    else if (sd && di == 3'h2) held <= 36'h0;
    else if (antenna_bottom_out) held <= held + 36'h1;
  end
  sequence s_pos_cmd;
    sd && di == 3'h2 && (uplink_in[11:9] inside {[3'h1:3'h3]});
  endsequence
  sequence s_pos_none;
    !(uplink_in[11:9] inside {[3'h1:3'h3]}) && sd && di == 3'h2 && !surface_pos_out
      && !$past(uplink_valid_in);
  endsequence
  property p_bds2; sd && di == 3'h7 |=> bds2_out == $past(uplink_in[11:8]); endproperty
  property p_si; sd && di == 3'h3 |=> si_code_out == $past(uplink_in[15:10]); endproperty
  property p_ant;
    sd && di == 3'h2 && uplink_in[5:4] != 2'h1
      |-> ##2 antenna_bottom_out == $past(uplink_in[5:4] == 2'h2, 2);
  endproperty
  property p_surf;
    s_pos_cmd |-> ##2 surface_pos_out == $past(uplink_in[11:9] != 3'h3, 2);
  endproperty
  property p_none; s_pos_none |-> ##2 !surface_pos_out; endproperty
  property p_unl; unlinked_msg_out == $past(unl); endproperty
  property p_link; link_done_out |-> $past(sd && uplink_in[3:0] == 4'hE); endproperty
  property p_hold; antenna_bottom_out |-> held < ANT_HOLD_CYC + 36'h4; endproperty
  a_bds2: assert property (p_bds2) else $error("bds2 not taken");
  a_si: assert property (p_si) else $error("si code not taken");
  a_ant: assert property (p_ant) else $error("antenna wrong");
  a_surf: assert property (p_surf) else $error("surface wrong");
  a_none: assert property (p_none) else $error("unassigned acted");
  a_unl: assert property (p_unl) else $error("unlinked pulse wrong");
  a_link: assert property (p_link) else $error("done without final");
  a_hold: assert property (p_hold) else $error("hold too long");
endmodule
bind mode_s_sd_decoder mode_s_sd_decoder_sva #(.ANT_HOLD_CYC(ANT_HOLD_CYC)) sva (.*);

// >>> mode_s_interrogator.sv
// Purpose: Ground interrogator sending uplink words
// Assumes: Caller lets an edge pass between calls
// Notes:   Released lines show the inverse so stale bits fail
`timescale 1ns/100ps
module mode_s_interrogator (
  input  wire logic   clk_in,
  output logic        uplink_valid_out,
  output logic [31:0] uplink_out
);
  initial begin
    uplink_valid_out = 1'b0;
    uplink_out       = 32'h0;
  end
  task automatic send(input logic [4:0] uf, input logic [2:0] di, input logic [15:0] sd);
    uplink_valid_out <= 1'b1;
    uplink_out       <= {uf, 8'h00, di, sd};
    @(posedge clk_in);
    uplink_valid_out <= 1'b0;
    uplink_out       <= ~{uf, 8'h00, di, sd};
  endtask
  // No resolution capability means the level carries nothing
  function automatic logic [2:0] sl_of(input logic [31:0] r, input logic [3:0] ri);
    return (ri == 4'h0) ? 3'h0 : r[23:21];
  endfunction
endmodule

// >>> mode_s_designator_field_decoder_tb.sv
// Purpose: Self-checking bench for the designator decoder
// Assumes: Timer counts cut to 20, 5 and 10 cycles
// Notes:   Expectations come from the field layout
`timescale 1ns/100ps
module mode_s_designator_field_decoder_tb;
  logic        clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, squitter_in, reply_req_in, uplink_valid_in;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, reply_valid_out, antenna_bottom_out, surface_pos_out;
  logic        unlinked_msg_out, link_done_out, a0;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
  logic [2:0]  link_count_out;
  logic [3:0]  s_axi_wstrb_in, bds2_out;
  logic [4:0]  reply_df_in;
  logic [5:0]  si_code_out, um;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, reply_base_in, s_axi_rdata_out, reply_out, uplink_in, rd;
  logic [4:0]  dfv [4] = '{5'h04, 5'h05, 5'h14, 5'h15};
  int          err_count = 0, n_compared = 0, cycles = 0;
  mode_s_sd_decoder #(.ANT_HOLD_CYC(36'h14), .POS_SHORT_CYC(36'h5), .POS_LONG_CYC(36'hA)) DUT (.*);
  mode_s_interrogator ip (.clk_in, .uplink_valid_out(uplink_valid_in), .uplink_out(uplink_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_bready_in  <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    chk("bresp", s_axi_bresp_out, er);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    s_axi_arvalid_in <= 1'b1;
    s_axi_araddr_in  <= a;
    s_axi_rready_in  <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_in); while (!s_axi_rvalid_out);
    rd = s_axi_rdata_out;
    chk("rresp", s_axi_rresp_out, er);
    s_axi_rready_in <= 1'b0;
  endtask
  // Waits w edges after the uplink edge; outputs read then are settled
  task automatic up(input logic [4:0] uf, input logic [2:0] di, input logic [15:0] sd, int w);
    ip.send(uf, di, sd);
    repeat (w) @(posedge clk_in);
  endtask
  task automatic rep(input logic [4:0] df);
    reply_req_in <= 1'b1;
    reply_df_in  <= df;
    @(posedge clk_in);
    reply_req_in <= 1'b0;
    @(posedge clk_in);
    chk("reply valid", reply_valid_out, 1'b1);
  endtask
  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, squitter_in, reply_req_in, rst_n_in} = 4'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, reply_df_in} = 53'h0;
    reply_base_in = 32'h0;
    s_axi_wstrb_in = 4'hF;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    axr(8'h00, 2'h0);
    chk("ctrl reset", rd, 32'h0);
    up(5'h04, 3'h7, 16'h0A00, 1);
    chk("bds2", bds2_out, 4'hA);
    up(5'h15, 3'h3, 16'hB400, 1);
    chk("si code", si_code_out, 6'h2D);
    up(5'h00, 3'h7, 16'h0300, 1);
    chk("bds2 kept", bds2_out, 4'hA);
    for (int t = 0; t < 4; t++) begin
      up(5'h14, 3'h7, 16'(t), 1);
      chk("unlinked", unlinked_msg_out, t != 0);
    end
    for (int f = 4; f < 12; f++) begin
      up(5'h04, 3'h1, 16'(f), 1);
      for (int s = 12; s < 15; s++) up(5'h04, 3'h1, 16'(s), 1);
      chk("link done", link_done_out, 1'b1);
      chk("link count", link_count_out, 3'h4);
    end
    up(5'h04, 3'h1, 16'h000D, 1);
    chk("early segment", link_done_out, 1'b0);
    axr(8'h08, 2'h0);
    chk("link error", rd[7], 1'b1);
    axw(8'h08, 32'h80, 2'h0);
    axr(8'h08, 2'h0);
    chk("error cleared", rd[7], 1'b0);
    $display("test designators done");
    for (int i = 0; i < 4; i++) begin
      up(5'h05, 3'h1, {4'(i + 5), 6'h0, 2'(i + 1), 4'h0}, 2);
      if (2'(i + 1) != 2'h0) um = {4'(i + 5), 2'(i + 1)};
      rep(dfv[i]);
      chk("util msg", reply_out[18:13], um);
    end
    axw(8'h00, 32'h5, 2'h0);
    axr(8'h00, 2'h0);
    chk("ctrl", rd, 32'h5);
    for (int i = 0; i < 2; i++) begin
      rep(5'(i * 16));
      chk("sens level", ip.sl_of(reply_out, 4'h2), 3'h5);
    end
    axw(8'h40, 32'h1, 2'h2);
    axr(8'h40, 2'h2);
    chk("unmapped", rd, 32'h0);
    $display("test replies done");
    up(5'h04, 3'h2, 16'h0020, 2);
    chk("bottom", antenna_bottom_out, 1'b1);
    repeat (12) @(posedge clk_in);
    chk("still bottom", antenna_bottom_out, 1'b1);
    repeat (12) @(posedge clk_in);
    chk("hold over", antenna_bottom_out, 1'b0);
    up(5'h00, 3'h2, 16'h0020, 2);
    chk("other format", antenna_bottom_out, 1'b0);
    for (int c = 0; c < 2; c++) begin
      up(5'h04, 3'h2, 16'h0020, 2);
      up(5'h04, 3'h2, 16'(c * 48), 2);
      chk("top again", antenna_bottom_out, 1'b0);
    end
    up(5'h04, 3'h2, 16'h0010, 2);
    a0 = antenna_bottom_out;
    squitter_in <= 1'b1;
    @(posedge clk_in);
    squitter_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("alternate", antenna_bottom_out, !a0);
    up(5'h04, 3'h2, 16'h0030, 2);
    $display("test antenna done");
    up(5'h04, 3'h2, 16'h0200, 2);
    chk("short surface", surface_pos_out, 1'b1);
    repeat (6) @(posedge clk_in);
    chk("short over", surface_pos_out, 1'b0);
    up(5'h04, 3'h2, 16'h0400, 2);
    up(5'h04, 3'h2, 16'h0800, 2);
    chk("long kept", surface_pos_out, 1'b1);
    up(5'h04, 3'h2, 16'h0600, 2);
    chk("cancelled", surface_pos_out, 1'b0);
    up(5'h04, 3'h2, 16'h0E00, 2);
    chk("still off", surface_pos_out, 1'b0);
    $display("test surface done");
    report_and_stop();
  end
endmodule
